// ===== hdl/serial_port_config_control.sv
// configuration, command and line control for one serial port
// assumes Avalon-MM master, sync serial-side strobes, one clock
//
// Summary of operation
// - run each one-shot command whose bit is set
// - override only when device does not own pins
// - break holds data output low until cleared
// - five-bit rate code selects listed baud rate
// - framing byte: data, stop, parity, stick bits
// - CD, CTS, DSR wait timers set timeout flags
// - flow characters come from configured codes
// - receive stop below low, release above high
// - replace parity-error characters when enabled
// - save code 0 none, 1 apply, 2 store
// - clear command wipes latched error indication
// - factory command restores defaults then resets
// - frozen RTS/DTR ignore connection changes
// - separate software flow enables per direction
// - CTS/DSR gate send; DTR/RTS signal receive
// - parity errors reported only when check enabled
// - separate flow-character filters per direction
// - unused RTS/DTR take default level after reset
// - error characters may not open client connection
`timescale 1ns/10ps
module serial_port_config_control
  import serial_cfg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic link_up_i,
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic cd_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_parity_err_i,
  input wire logic rx_frame_err_i,
  input wire logic rx_overrun_i,
  input wire logic [15:0] rx_free_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic txd_i,
  output logic rts_o,
  output logic dtr_o,
  output logic txd_o,
  output logic [7:0] rx_out_data_o,
  output logic rx_out_valid_o,
  output logic [7:0] tx_out_data_o,
  output logic tx_out_valid_o,
  output logic tx_enable_o,
  output logic send_pause_o,
  output logic send_resume_o,
  output logic flush_rx_o,
  output logic flush_tx_o,
  output logic open_conn_o,
  output logic [17:0] rate_bps_o,
  output logic [5:0] frame_o,
  output logic nv_write_o,
  output logic device_reset_o,
  output logic error_led_o
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [15:0] frame_q, cd_tmo_q;
  logic [31:0] line_tmo_q, thresh_q, act_thresh_q;
  logic [23:0] chars_q, act_chars_q;
  logic [19:0] flags_q, act_flags_q;
  logic [47:0] act_tmo_q;
  logic [4:0] act_rate_q;
  logic [5:0] err_q;
  logic [1:0] man_q;
  logic [TW-1:0] tick_cnt_q;
  logic tick_q, break_q, rx_stop_q, tx_paused_q;

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  wire req = avs_read_i | avs_write_i;
  wire rd_take = req & avs_waitrequest_o;
  wire wr_en = avs_write_i & ~avs_waitrequest_o;
  wire [31:0] wd = avs_writedata_i;
  wire sel_frame = wr_en & (avs_address_i == OFS_FRAME);
  wire sel_cd = wr_en & (avs_address_i == OFS_CD_TMO);
  wire sel_line = wr_en & (avs_address_i == OFS_LINE_TMO);
  wire sel_chars = wr_en & (avs_address_i == OFS_CHARS);
  wire sel_thr = wr_en & (avs_address_i == OFS_THRESH);
  wire sel_flags = wr_en & (avs_address_i == OFS_FLAGS);
  wire cmd_fire = wr_en & (avs_address_i == OFS_CMD);
  wire [3:0] save_code = wd[C_SAVE_LSB +: 4];
  wire apply = cmd_fire & (save_code == SAVE_APPLY ||
                           save_code == SAVE_STORE);
  wire store = cmd_fire & (save_code == SAVE_STORE);
  wire fact = cmd_fire & wd[C_FACT];
  wire clr_err = cmd_fire & wd[C_CLR_ERR];
  wire brk_set = cmd_fire & wd[C_SET_BRK];
  wire brk_clr = cmd_fire & wd[C_CLR_BRK];
  wire [17:0] new_bps = rate_bps(frame_q[4:0]);
  wire rate_ok = (new_bps != 18'h00000);

  wire [15:0] status_w = {dtr_o, rts_o, cd_i, dsr_i, cts_i, tx_paused_q,
                          rx_stop_q, break_q, 2'b00, err_q};
  wire [31:0] rd_mux =
    (avs_address_i == OFS_FRAME) ? {16'h0000, frame_q} :
    (avs_address_i == OFS_CD_TMO) ? {16'h0000, cd_tmo_q} :
    (avs_address_i == OFS_LINE_TMO) ? line_tmo_q :
    (avs_address_i == OFS_CHARS) ? {8'h00, chars_q} :
    (avs_address_i == OFS_THRESH) ? thresh_q :
    (avs_address_i == OFS_FLAGS) ? {12'h000, flags_q} :
    (avs_address_i == OFS_STATUS) ? {16'h0000, status_w} :
    (avs_address_i == OFS_ACTIVE) ?
      {act_flags_q[15:0], 2'b00, frame_o, 3'b000, act_rate_q} :
    32'h0000_0000;

  // one wait state per access; data stands at the accept edge
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_o <= ~rd_take;
      if (rd_take && avs_read_i)
        avs_readdata_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // staged configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || fact)
    begin
      frame_q <= RST_FRAME;
      cd_tmo_q <= 16'h0000;
      line_tmo_q <= 32'h0000_0000;
      chars_q <= RST_CHARS;
      thresh_q <= RST_THRESH;
      flags_q <= RST_FLAGS;
    end
    else
    begin
      if (sel_frame)
        frame_q <= {2'b00, wd[13:8], 3'b000, wd[4:0]};
      if (sel_cd)
        cd_tmo_q <= wd[15:0];
      if (sel_line)
        line_tmo_q <= wd;
      if (sel_chars)
        chars_q <= wd[23:0];
      if (sel_thr)
        thresh_q <= wd;
      if (sel_flags)
        flags_q <= wd[19:0];
    end
  end

  // ----------------------------------------------------------------
  // active configuration and save
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || fact)
    begin
      act_rate_q <= RST_FRAME[4:0];
      rate_bps_o <= rate_bps(RST_FRAME[4:0]);
      frame_o <= RST_FRAME[13:8];
      act_tmo_q <= 48'h0000_0000_0000;
      act_chars_q <= RST_CHARS;
      act_thresh_q <= RST_THRESH;
      act_flags_q <= RST_FLAGS;
    end
    else if (apply)
    begin
      if (rate_ok)
      begin
        act_rate_q <= frame_q[4:0];
        rate_bps_o <= new_bps;
      end
      frame_o <= frame_q[13:8];
      act_tmo_q <= {line_tmo_q, cd_tmo_q};
      act_chars_q <= chars_q;
      act_thresh_q <= thresh_q;
      act_flags_q <= flags_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      nv_write_o <= 1'b0;
      device_reset_o <= 1'b0;
    end
    else
    begin
      nv_write_o <= store;
      device_reset_o <= fact;
    end
  end

  // ----------------------------------------------------------------
  // one-shot commands and break
  // ----------------------------------------------------------------
  wire f_rts_dis = act_flags_q[F_RTS_DIS];
  wire f_dtr_dis = act_flags_q[F_DTR_DIS];
  wire f_inx_rts = act_flags_q[F_INX_RTS];
  wire f_inx_dtr = act_flags_q[F_INX_DTR];
  wire lines_free = f_rts_dis & f_dtr_dis & ~f_inx_rts & ~f_inx_dtr;
  wire set_lines = cmd_fire & wd[C_SET_LINES] & lines_free;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      break_q <= 1'b0;
      txd_o <= 1'b1;
      flush_rx_o <= 1'b0;
      flush_tx_o <= 1'b0;
    end
    else
    begin
      break_q <= brk_set | (break_q & ~brk_clr);
      txd_o <= break_q ? 1'b0 : txd_i;
      flush_rx_o <= cmd_fire & wd[C_FLUSH_RD];
      flush_tx_o <= cmd_fire & wd[C_FLUSH_WR];
    end
  end

  // ----------------------------------------------------------------
  // RTS / DTR outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      man_q <= {RST_FLAGS[F_RTS_DEF], RST_FLAGS[F_DTR_DEF]};
    else if (fact)
      man_q <= {RST_FLAGS[F_RTS_DEF], RST_FLAGS[F_DTR_DEF]};
    else if (set_lines)
      man_q <= {wd[C_RTS_HOLD], wd[C_DTR_HOLD]};
    else if (apply)
      man_q <= {flags_q[F_RTS_DEF], flags_q[F_DTR_DEF]};
  end

  wire rts_d = f_inx_rts ? ~rx_stop_q :
               (~f_rts_dis ? link_up_i : man_q[1]);
  wire dtr_d = f_inx_dtr ? ~rx_stop_q :
               (~f_dtr_dis ? link_up_i : man_q[0]);

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rts_o <= 1'b0;
      dtr_o <= 1'b0;
    end
    else
    begin
      rts_o <= rts_d;
      dtr_o <= dtr_d;
    end
  end

  // ----------------------------------------------------------------
  // flow control and character streams
  // ----------------------------------------------------------------
  wire [7:0] resume_char = act_chars_q[7:0];
  wire [7:0] pause_char = act_chars_q[15:8];
  wire [15:0] flow_release_threshold = act_thresh_q[15:0];
  wire [15:0] flow_stop_threshold = act_thresh_q[31:16];
  wire rx_res = rx_data_i == resume_char;
  wire rx_pau = rx_data_i == pause_char;
  wire rx_drop = act_flags_q[F_INXFILT] & (rx_res | rx_pau);
  wire rx_rep = act_flags_q[F_PECHAR] & rx_parity_err_i;
  wire tx_drop = act_flags_q[F_OUTXFILT] &
                 (tx_data_i == resume_char || tx_data_i == pause_char);
  wire stop_d = (rx_free_i < flow_stop_threshold) ? 1'b1 :
                (rx_free_i > flow_release_threshold) ? 1'b0 : rx_stop_q;
  wire f_inx = act_flags_q[F_INX];
  wire err_bad = rx_parity_err_i | rx_frame_err_i;
  wire tx_gate = (~act_flags_q[F_OUTX_CTS] | cts_i) &
                 (~act_flags_q[F_OUTX_DSR] | dsr_i);

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rx_stop_q <= 1'b0;
      tx_paused_q <= 1'b0;
      send_pause_o <= 1'b0;
      send_resume_o <= 1'b0;
      tx_enable_o <= 1'b0;
      open_conn_o <= 1'b0;
    end
    else
    begin
      rx_stop_q <= stop_d;
      if (!act_flags_q[F_OUTX])
        tx_paused_q <= 1'b0;
      else if (rx_valid_i && rx_pau)
        tx_paused_q <= 1'b1;
      else if (rx_valid_i && rx_res)
        tx_paused_q <= 1'b0;
      send_pause_o <= (cmd_fire & wd[C_SEND_PAUSE]) |
                      (f_inx & stop_d & ~rx_stop_q);
      send_resume_o <= f_inx & ~stop_d & rx_stop_q;
      tx_enable_o <= ~break_q & ~tx_paused_q & tx_gate;
      open_conn_o <= rx_valid_i &
                     ~(act_flags_q[F_ERR_QUIET] & err_bad);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rx_out_valid_o <= 1'b0;
      rx_out_data_o <= 8'h00;
      tx_out_valid_o <= 1'b0;
      tx_out_data_o <= 8'h00;
    end
    else
    begin
      rx_out_valid_o <= rx_valid_i & ~rx_drop;
      rx_out_data_o <= rx_rep ? act_chars_q[23:16] : rx_data_i;
      tx_out_valid_o <= tx_valid_i & ~tx_drop;
      tx_out_data_o <= tx_data_i;
    end
  end

  // ----------------------------------------------------------------
  // line wait timers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || tick_cnt_q == TW'(TICK_CYCLES - 1))
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      tick_q <= 1'b0;
    else
      tick_q <= (tick_cnt_q == TW'(TICK_CYCLES - 1));
  end

  wire [2:0] line_act = {cd_i, dsr_i, cts_i};
  wire [2:0] tmo_hit;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_tmr
      logic [15:0] cnt_q;
      wire [15:0] limit = (gi == 0) ? act_tmo_q[31:16] :
                          (gi == 1) ? act_tmo_q[47:32] : act_tmo_q[15:0];
      always_ff @(posedge clk_i)
      begin
        if (!reset_n_i || line_act[gi])
          cnt_q <= 16'h0000;
        else if (tick_q && cnt_q != 16'hFFFF)
          cnt_q <= cnt_q + 16'h0001;
      end
      assign tmo_hit[gi] = (limit != 16'h0000) & ~line_act[gi] &
                           (cnt_q > limit);
    end
  endgenerate

  // ----------------------------------------------------------------
  // latched errors; a new event wins over a clear
  // ----------------------------------------------------------------
  wire [5:0] err_set = {rx_overrun_i, rx_valid_i & rx_frame_err_i,
                        rx_valid_i & rx_parity_err_i &
                        act_flags_q[F_PARITY],
                        tmo_hit[2], tmo_hit[1], tmo_hit[0]};
  wire [5:0] err_d = (err_q & ~{6{clr_err}}) | err_set;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      err_q <= 6'h00;
      error_led_o <= 1'b0;
    end
    else
    begin
      err_q <= err_d;
      error_led_o <= |err_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_request;
    req && avs_waitrequest_o;
  endsequence
  sequence s_accept;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  a_bus_accept: assert property (s_request |=> s_accept)
    else $error("access not accepted after one wait state");
  a_break_level: assert property (brk_set |=> break_q ##1 !txd_o)
    else $error("break did not drive data output low");
  a_break_hold: assert property (break_q && !brk_clr |=> !txd_o)
    else $error("data output left break level");
  a_stop_set: assert property
    (rx_free_i < flow_stop_threshold |=> rx_stop_q)
    else $error("receive stop not raised");
  a_stop_release: assert property
    (!(rx_free_i < flow_stop_threshold) &&
     rx_free_i > flow_release_threshold |=> !rx_stop_q)
    else $error("receive stop not released");
  a_char_replace: assert property
    (rx_valid_i && !rx_drop && rx_rep |=>
     rx_out_valid_o && rx_out_data_o == $past(act_chars_q[23:16]))
    else $error("parity error character not replaced");
  a_rate_keep: assert property (apply && !rate_ok && !fact |=>
    $stable(rate_bps_o) && $stable(act_rate_q))
    else $error("invalid rate code changed active rate");
  a_save_store: assert property
    (store && !fact |=> nv_write_o && frame_o == $past(frame_q[13:8]))
    else $error("store command did not apply and write");
  a_save_none: assert property
    (cmd_fire && save_code == 4'h0 && !fact |=> !nv_write_o &&
     $stable(act_flags_q))
    else $error("save code zero changed configuration");
  a_factory_reset: assert property (fact |=> device_reset_o &&
    act_flags_q == RST_FLAGS ##1 !device_reset_o)
    else $error("factory command did not restore and reset");
  a_error_clear: assert property
    (clr_err && err_set == 6'h00 |=> err_q == 6'h00 && !error_led_o)
    else $error("error clear did not wipe latched errors");
  a_cts_gate: assert property
    (act_flags_q[F_OUTX_CTS] && !cts_i |=> !tx_enable_o)
    else $error("transmit enabled with CTS inactive");
  a_parity_off: assert property
    (!act_flags_q[F_PARITY] && !err_q[E_PARITY] && !rx_overrun_i |=>
     !err_q[E_PARITY])
    else $error("parity error reported while check disabled");
  a_quiet_error: assert property
    (rx_valid_i && err_bad && act_flags_q[F_ERR_QUIET] |=> !open_conn_o)
    else $error("error character opened connection");
  a_freeze_rts: assert property
    (f_rts_dis && !f_inx_rts && !set_lines && !apply && !fact &&
     $changed(link_up_i) |=> ##1 rts_o == $past(man_q[1], 2))
    else $error("frozen RTS followed connection state");
endmodule

// ===== hdl/serial_cfg_pkg.sv
// constants for the serial port configuration and command block
// assumes one 100 MHz clock and a byte-addressed register slave
package serial_cfg_pkg;
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000000; // timeout unit, 1 ms
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // byte offsets
  localparam logic [5:0] OFS_FRAME = 6'h00;
  localparam logic [5:0] OFS_CD_TMO = 6'h04;
  localparam logic [5:0] OFS_LINE_TMO = 6'h08;
  localparam logic [5:0] OFS_CHARS = 6'h0C;
  localparam logic [5:0] OFS_THRESH = 6'h10;
  localparam logic [5:0] OFS_FLAGS = 6'h14;
  localparam logic [5:0] OFS_CMD = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1C;
  localparam logic [5:0] OFS_ACTIVE = 6'h20;
  // option flag positions
  localparam int F_RTS_DIS = 0, F_DTR_DIS = 1, F_OUTX = 2, F_INX = 3;
  localparam int F_OUTX_CTS = 4, F_OUTX_DSR = 5, F_INX_DTR = 6;
  localparam int F_INX_RTS = 7, F_PARITY = 8, F_PECHAR = 9;
  localparam int F_INXFILT = 10, F_OUTXFILT = 11, F_RTS_DEF = 12;
  localparam int F_DTR_DEF = 13, F_ERR_QUIET = 15;
  // command word positions
  localparam int C_DTR_HOLD = 4, C_RTS_HOLD = 5, C_SEND_PAUSE = 7;
  localparam int C_FLUSH_RD = 8, C_FLUSH_WR = 9, C_SET_LINES = 10;
  localparam int C_SET_BRK = 11, C_CLR_BRK = 12, C_SAVE_LSB = 16;
  localparam int C_CLR_ERR = 20, C_FACT = 21;
  localparam logic [3:0] SAVE_APPLY = 4'h1;
  localparam logic [3:0] SAVE_STORE = 4'h2;
  // error flag positions
  localparam int E_CTS_TO = 0, E_DSR_TO = 1, E_CD_TO = 2;
  localparam int E_PARITY = 3, E_FRAME = 4, E_RX_OVER = 5;
  // factory values
  localparam logic [15:0] RST_FRAME = 16'h0303;
  localparam logic [23:0] RST_CHARS = 24'h3F1311;
  localparam logic [31:0] RST_THRESH = 32'h0080_0200;
  localparam logic [19:0] RST_FLAGS = 20'h00000;

  function automatic logic [17:0] rate_bps(input logic [4:0] c);
    case (c)
      5'h0B: rate_bps = 18'h38400;
      5'h0E: rate_bps = 18'h25800;
      5'h0F: rate_bps = 18'h1C200;
      5'h00: rate_bps = 18'h0E100;
      5'h01: rate_bps = 18'h09600;
      5'h02: rate_bps = 18'h04B00;
      5'h03: rate_bps = 18'h02580;
      5'h05: rate_bps = 18'h012C0;
      5'h06: rate_bps = 18'h00960;
      5'h07: rate_bps = 18'h004B0;
      5'h08: rate_bps = 18'h00258;
      5'h09: rate_bps = 18'h0012C;
      5'h0A: rate_bps = 18'h00096;
      5'h10: rate_bps = 18'h0006E;
      5'h0C: rate_bps = 18'h0004B;
      5'h0D: rate_bps = 18'h00032;
      default: rate_bps = 18'h00000;
    endcase
  endfunction
endpackage

// ===== bench/avs_client.sv
// network client model: drives the register slave over Avalon-MM
// assumes a slave with waitrequest on clk_i and package constants
`timescale 1ns/10ps
module avs_client
  import serial_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic avs_waitrequest_i,
  input wire logic [31:0] avs_readdata_i,
  output logic [5:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic hung_o
);
  initial
  begin
    avs_address_o = 6'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h00000000;
    hung_o = 1'b0;
  end
  // ---------------------------------------------------------------
  // one access, held until waitrequest is seen low at a rising edge
  // ---------------------------------------------------------------
  task automatic xfer(input logic rd, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_o <= a;
    avs_read_o <= rd;
    avs_write_o <= !rd;
    avs_writedata_o <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_i !== 1'b0 && n < 50);
    q = avs_readdata_i;
    if (n >= 50)
      hung_o <= 1'b1;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
  endtask
  // override carries wanted levels in hold bits
  task automatic set_lines(input logic rts, input logic dtr);
    logic [31:0] q;
    xfer(1'b0, OFS_CMD, 32'h00000400 | {26'h0, rts, dtr, 4'h0}, q);
  endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the serial port configuration block
// assumes serial_cfg_pkg, the design and the avs_client model
`timescale 1ns/10ps
module tb_top
  import serial_cfg_pkg::*;
;
  logic clk_i, reset_n_i, link_up_i, cts_i, dsr_i, cd_i, txd_i;
  logic rx_valid_i, rx_parity_err_i, rx_frame_err_i, tx_valid_i;
  logic rx_overrun_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [7:0] rx_data_i, tx_data_i, rx_out_data_o, tx_out_data_o;
  logic [15:0] rx_free_i;
  logic [5:0] avs_address_i, frame_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic rts_o, dtr_o, txd_o, rx_out_valid_o, tx_out_valid_o, hung;
  logic error_led_o, nv_write_o, device_reset_o;
  logic tx_enable_o, send_pause_o, send_resume_o, flush_rx_o, flush_tx_o;
  logic open_conn_o, paused = 1'b0;
  logic [31:0] fl_cur = 32'h0;
  logic [17:0] rate_bps_o;
  int error_cnt = 0, n_compared = 0, nv_n = 0, rst_n = 0;
  int fl_n = 0, sp_n = 0, sr_n = 0;

  serial_port_config_control #(.TICK_CYCLES(10)) dut (.clk_i,
    .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .link_up_i,
    .cts_i, .dsr_i, .cd_i, .rx_data_i, .rx_valid_i, .rx_parity_err_i,
    .rx_frame_err_i, .rx_overrun_i, .rx_free_i, .tx_data_i, .tx_valid_i,
    .txd_i, .rts_o, .dtr_o, .txd_o, .rx_out_data_o, .rx_out_valid_o,
    .tx_out_data_o, .tx_out_valid_o, .tx_enable_o, .send_pause_o,
    .send_resume_o, .flush_rx_o, .flush_tx_o, .open_conn_o,
    .rate_bps_o, .frame_o, .nv_write_o, .device_reset_o, .error_led_o);
  avs_client client (.clk_i, .avs_waitrequest_i(avs_waitrequest_o),
    .avs_readdata_i(avs_readdata_o), .avs_address_o(avs_address_i),
    .avs_read_o(avs_read_i), .avs_write_o(avs_write_i),
    .avs_writedata_o(avs_writedata_i), .hung_o(hung));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    nv_n <= nv_n + int'(nv_write_o === 1'b1);
    rst_n <= rst_n + int'(device_reset_o === 1'b1);
    fl_n <= fl_n + int'(flush_rx_o === 1'b1) + int'(flush_tx_o === 1'b1);
    sp_n <= sp_n + int'(send_pause_o === 1'b1);
    sr_n <= sr_n + int'(send_resume_o === 1'b1);
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [5:0] a, input logic [31:0] d);
    client.xfer(1'b0, a, d, q);
  endtask
  task automatic cfg(input logic [31:0] fl, input logic [31:0] ch);
    fl_cur = fl;
    w(OFS_FLAGS, fl);
    w(OFS_CHARS, ch);
    w(OFS_CMD, 32'h00010000);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic int exp_rate(input int c, input int cur);
    case (c)
      11: return 230400;
      14: return 153600;
      15: return 115200;
      0: return 57600;
      1: return 38400;
      2: return 19200;
      3: return 9600;
      5: return 4800;
      6: return 2400;
      7: return 1200;
      8: return 600;
      9: return 300;
      10: return 150;
      16: return 110;
      12: return 75;
      13: return 50;
      default: return cur;
    endcase
  endfunction
  task automatic rx_char(input logic [7:0] d, input logic pe,
                         input logic fe, input logic [7:0] exp,
                         input logic kept);
    @(posedge clk_i);
    rx_data_i <= d;
    rx_valid_i <= 1'b1;
    rx_parity_err_i <= pe;
    rx_frame_err_i <= fe;
    tx_data_i <= ~d;
    tx_valid_i <= 1'b1;
    cts_i <= 1'($urandom);
    dsr_i <= 1'($urandom);
    rx_free_i <= 16'($urandom);
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    tx_valid_i <= 1'b0;
    #1;
    cmp(rx_out_valid_o, kept);
    if (kept)
      cmp(rx_out_data_o, exp);
    cmp({tx_out_valid_o, tx_out_data_o}, {1'b1, ~d});
    cmp(open_conn_o, !(fl_cur[F_ERR_QUIET] && (pe || fe)));
    cmp(tx_enable_o, !paused && (!fl_cur[F_OUTX_CTS] || cts_i) &&
        (!fl_cur[F_OUTX_DSR] || dsr_i));
    if (fl_cur[F_OUTX] && d == 8'h93)
      paused = 1'b1;
    else if (d == 8'h91 || !fl_cur[F_OUTX])
      paused = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    int cur;
    int k;
    int j;
    int sv;
    logic [5:0] f;
    logic [5:0] fe;
    logic [7:0] d;
    {reset_n_i, link_up_i, cts_i, dsr_i, cd_i, rx_valid_i} = 6'h00;
    {rx_parity_err_i, rx_frame_err_i, tx_valid_i, rx_overrun_i} = 4'h0;
    {rx_data_i, tx_data_i, rx_free_i} = 32'h00000000;
    txd_i = 1'b1;
    cd_i = 1'b1;
    void'($urandom(32'h60c26791));
    settle(16);
    cmp({rate_bps_o, frame_o, txd_o}, {18'h02580, 6'h03, 1'b1});
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    cur = 9600;
    fe = 6'h03;
    for (int c = 0; c < 32; c++)
    begin
      f = {4'($urandom), 1'b1, 1'($urandom)};
      sv = (c % 8 == 7) ? 0 : ((c % 8 == 3) ? 2 : 1);
      w(OFS_FRAME, {18'h0, f, 3'h0, 5'(c)});
      w(OFS_CMD, {12'h0, 4'(sv), 16'h0});
      if (sv != 0)
      begin
        cur = exp_rate(c, cur);
        fe = f;
      end
      settle(2);
      cmp(rate_bps_o, cur);
      cmp(frame_o, fe);
    end
    cmp(nv_n, 4);
    cfg(32'h0, 32'h00A59391);
    for (int i = 0; i < 40; i++)
    begin
      d = 8'($urandom);
      rx_char(d, 1'($urandom), i == 5, d, 1'b1);
    end
    cmp(error_led_o, 1'b1);
    w(OFS_CMD, 32'h1 << C_CLR_ERR);
    rx_char(8'h41, 1'b1, 1'b0, 8'h41, 1'b1);
    settle(2);
    cmp(error_led_o, 1'b0);
    cfg((1 << F_PECHAR) | (1 << F_PARITY) | (1 << F_INXFILT)
        | (1 << F_INX), 32'h00A59391);
    rx_char(8'h41, 1'b1, 1'b0, 8'hA5, 1'b1);
    rx_char(8'h91, 1'b0, 1'b0, 8'h00, 1'b0);
    rx_char(8'h11, 1'b0, 1'b0, 8'h11, 1'b1);
    settle(1);
    cmp(error_led_o, 1'b1);
    cfg((1 << F_OUTX) | (1 << F_OUTX_CTS) | (1 << F_ERR_QUIET),
        32'h00A59391);
    rx_char(8'h93, 1'b1, 1'b0, 8'h93, 1'b1);
    rx_char(8'h91, 1'b0, 1'b1, 8'h91, 1'b1);
    w(OFS_CD_TMO, 32'h3);
    cfg(32'h3, 32'h00A59391);
    w(OFS_CMD, 32'h1 << C_CLR_ERR);
    cd_i <= 1'b0;
    settle(22);
    client.xfer(1'b1, OFS_STATUS, 32'h0, q);
    cmp(q[E_CD_TO], 1'b0);
    settle(20);
    client.xfer(1'b1, OFS_STATUS, 32'h0, q);
    cmp(q[E_CD_TO], 1'b1);
    cfg(32'h300B, 32'h00A59391);
    @(posedge clk_i);
    rx_free_i <= 16'h0300;
    settle(3);
    k = sp_n;
    j = sr_n;
    @(posedge clk_i);
    rx_free_i <= 16'h0010;
    settle(3);
    cmp(sp_n - k, 1);
    client.xfer(1'b1, OFS_STATUS, 32'h0, q);
    cmp(q[9], 1'b1);
    @(posedge clk_i);
    rx_free_i <= 16'h0300;
    settle(3);
    cmp(sr_n - j, 1);
    cmp({rts_o, dtr_o}, 2'b11);
    client.set_lines(1'b1, 1'b0);
    settle(2);
    cmp({rts_o, dtr_o}, 2'b10);
    @(posedge clk_i);
    link_up_i <= 1'b1;
    settle(3);
    cmp({rts_o, dtr_o}, 2'b10);
    w(OFS_CMD, 32'h1 << C_SET_BRK);
    settle(3);
    cmp(txd_o, 1'b0);
    client.xfer(1'b1, OFS_STATUS, 32'h0, q);
    cmp(q[8], 1'b1);
    w(OFS_CMD, 32'h1 << C_CLR_BRK);
    settle(3);
    cmp(txd_o, 1'b1);
    k = sp_n;
    w(OFS_CMD, 32'h380);
    settle(2);
    cmp(fl_n, 2);
    cmp(sp_n - k, 1);
    w(OFS_CMD, 32'h1 << C_FACT);
    settle(3);
    cmp({rate_bps_o, frame_o}, {18'h02580, 6'h03});
    cmp(rst_n, 1);
    cmp(hung, 1'b0);
    report_and_stop();
  end
endmodule
